// ==== core/ldc_reg_bank.sv ====
/*
  LED drive and operating control register bank with start-up sequencer
  and FIFO record gating. Assumes the serial host link has already turned
  transactions into single-cycle register reads and writes, and that a
  one-cycle tick marks each period of the 32 kHz slow clock.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - Gesture current code n drives 25 mA plus 15 mA per step.
// - Proximity current code lives in bits 11:8, same mapping, proximity only.
// - In proximity, select bit 12 picks proximity code, else gesture code.
// - Bits 11:8 of timing register give fast oscillator start-up interval.
// - Front-end phase lasts low-nibble count of 32 kHz periods.
// - State 0 standby, 1 proximity, 3 sample, 2 gesture, run like sample.
// - State 0xF is idle: bandgap, reference, bias on, rest asleep.
// - Proximity format 1 stores intensity only, two bytes.
// - Proximity format 3 stores x, y, intensity, six bytes.
// - Other proximity formats store nothing.
// - Sample or gesture operation stores four bytes per record.
// - Bit 8 of operating control enables overrun guard, reset zero.
// - Guard on: write whole record only if it fits, else drop.
module ldc_reg_bank
    import ldc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    output logic      [15:0] o_reg_rdata,
    // Slow clock tick
    input  wire logic        i_tick_32k,
    // Record source and FIFO space
    input  wire logic        i_rec_valid,
    input  wire logic [15:0] i_rec_x,
    input  wire logic [15:0] i_rec_y,
    input  wire logic [15:0] i_rec_i,
    input  wire logic [7:0]  i_fifo_free,
    // FIFO record output
    output logic             o_rec_write,
    output logic             o_rec_dropped,
    output logic      [3:0]  o_rec_bytes,
    output logic      [47:0] o_rec_data,
    // LED drive
    output logic      [3:0]  o_led_current_code,
    output logic      [7:0]  o_led_current_ma,
    output logic      [2:0]  o_led_slew_ctrl,
    // Power and phase
    output logic             o_standby,
    output logic             o_bias_on,
    output logic             o_blocks_on,
    output logic             o_ref_phase,
    output logic             o_osc_phase,
    output logic             o_afe_phase,
    output logic             o_run,
    output logic      [15:0] o_sample_window_count
);

    // ============================================================
    // Register storage
    logic [15:0] led_reg;
    logic [15:0] startup_reg;
    logic [15:0] frontend_reg;
    logic [15:0] window_reg;
    logic [15:0] opctl_reg;

    wire logic wr_led   = i_reg_wr && (i_reg_addr == ADDR_LED_DRIVE);
    wire logic wr_start = i_reg_wr && (i_reg_addr == ADDR_STARTUP);
    wire logic wr_fe    = i_reg_wr && (i_reg_addr == ADDR_FRONTEND);
    wire logic wr_win   = i_reg_wr && (i_reg_addr == ADDR_WINDOW);
    wire logic wr_op    = i_reg_wr && (i_reg_addr == ADDR_OPCTL);

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            led_reg      <= RST_LED_DRIVE;
            startup_reg  <= RST_STARTUP;
            frontend_reg <= RST_FRONTEND;
            window_reg   <= RST_WINDOW;
            opctl_reg    <= RST_OPCTL;
        end
        else
        begin
            if (wr_led)
                led_reg <= i_reg_wdata & MASK_LED_DRIVE;
            if (wr_start)
                startup_reg <= i_reg_wdata & MASK_STARTUP;
            if (wr_fe)
                frontend_reg <= i_reg_wdata & MASK_FRONTEND;
            // The window count is taken as written; computing it is the host's job.
            if (wr_win)
                window_reg <= i_reg_wdata & MASK_WINDOW;
            if (wr_op)
                opctl_reg <= i_reg_wdata & MASK_OPCTL;
        end
    end

    // ============================================================
    // Read path; unmapped addresses read zero
    wire logic [15:0] rd_mux = (i_reg_addr == ADDR_LED_DRIVE) ? led_reg :
                               (i_reg_addr == ADDR_STARTUP)   ? startup_reg :
                               (i_reg_addr == ADDR_FRONTEND)  ? frontend_reg :
                               (i_reg_addr == ADDR_WINDOW)    ? window_reg :
                               (i_reg_addr == ADDR_OPCTL)     ? opctl_reg : 16'h0000;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_reg_rdata <= 16'h0000;
        else if (i_reg_rd)
            o_reg_rdata <= rd_mux;
    end

    // ============================================================
    // Field decode
    wire logic [3:0] gest_led_current_code = led_reg[POS_GEST_CODE +: 4];
    wire logic [2:0] led_slew_ctrl         = led_reg[POS_SLEW +: 3];
    wire logic [3:0] prox_led_current_code = led_reg[POS_PROX_CODE +: 4];
    wire logic       prox_current_select   = led_reg[POS_PROX_SEL];
    wire logic [7:0] ref_settle_count      = startup_reg[POS_REF_TIME +: 8];
    wire logic [3:0] fast_osc_settle_count = startup_reg[POS_OSC_TIME +: 4];
    wire logic [3:0] frontend_phase_count  = frontend_reg[POS_FRONTEND_PHASE_COUNT +: 4];
    wire logic [3:0] operating_state       = opctl_reg[POS_STATE +: 4];
    wire logic [3:0] fifo_format           = opctl_reg[POS_FORMAT +: 4];
    wire logic       overrun_guard_en      = opctl_reg[POS_GUARD];

    wire logic st_prox    = (operating_state == OPST_PROX);
    wire logic st_active  = st_prox || (operating_state == OPST_SAMPLE) ||
                            (operating_state == OPST_GESTURE);
    wire logic st_standby = (operating_state == OPST_STANDBY);
    wire logic st_idle    = (operating_state == OPST_IDLE);

    // ============================================================
    // LED current selection and mapping
    wire logic [3:0] led_code_next = (st_prox && prox_current_select) ? prox_led_current_code
                                                                      : gest_led_current_code;
    wire logic [7:0] led_ma_next   = LED_BASE_MA + 8'(LED_STEP_MA * {4'h0, led_code_next});

    // ============================================================
    // Start-up sequencer, timed in slow-clock ticks
    ldc_seq_type seq_reg;
    ldc_seq_type seq_next;
    logic [7:0]  cnt_reg;

    wire logic [7:0] phase_limit = (seq_reg == SEQ_REF) ? ref_settle_count :
                                   (seq_reg == SEQ_OSC) ? {4'h0, fast_osc_settle_count} :
                                   (seq_reg == SEQ_AFE) ? {4'h0, frontend_phase_count} :
                                   8'h00;
    wire logic       phase_done  = (cnt_reg == phase_limit);

    always_comb
    begin
        seq_next = seq_reg;
        if (!st_active)
            seq_next = SEQ_OFF;
        else
        begin
            case (seq_reg)
                SEQ_OFF: seq_next = SEQ_REF;
                SEQ_REF: seq_next = phase_done ? SEQ_OSC : SEQ_REF;
                SEQ_OSC: seq_next = phase_done ? SEQ_AFE : SEQ_OSC;
                SEQ_AFE: seq_next = phase_done ? SEQ_RUN : SEQ_AFE;
                SEQ_RUN: seq_next = SEQ_RUN;
                default: seq_next = SEQ_OFF;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            seq_reg <= SEQ_OFF;
            cnt_reg <= 8'h00;
        end
        else
        begin
            seq_reg <= seq_next;
            if (seq_next != seq_reg)
                cnt_reg <= 8'h00;
            else if (i_tick_32k && !phase_done)
                cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // ============================================================
    // Record gating
    logic [3:0] gate_bytes;
    logic       gate_write;
    logic       gate_drop;

    ldc_record_gate u_gate
    (
        .i_state     (operating_state),
        .i_format    (fifo_format),
        .i_guard_en  (overrun_guard_en),
        .i_rec_valid (i_rec_valid),
        .i_fifo_free (i_fifo_free),
        .o_bytes     (gate_bytes),
        .o_write     (gate_write),
        .o_drop      (gate_drop)
    );

    // Records are packed low-aligned; unused upper bytes read zero.
    wire logic [47:0] rec_data_next = (gate_bytes == REC_BYTES_XYI)    ? {i_rec_x, i_rec_y, i_rec_i} :
                                      (gate_bytes == REC_BYTES_SAMPLE) ? {16'h0000, i_rec_x, i_rec_y} :
                                      (gate_bytes == REC_BYTES_I)      ? {32'h0000_0000, i_rec_i} :
                                      48'h0000_0000_0000;

    // ============================================================
    // Output registers
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rec_write           <= 1'b0;
            o_rec_dropped         <= 1'b0;
            o_rec_bytes           <= REC_BYTES_NONE;
            o_rec_data            <= 48'h0000_0000_0000;
            o_led_current_code    <= 4'h0;
            o_led_current_ma      <= LED_BASE_MA;
            o_led_slew_ctrl       <= 3'h0;
            o_standby             <= 1'b1;
            o_bias_on             <= 1'b0;
            o_blocks_on           <= 1'b0;
            o_ref_phase           <= 1'b0;
            o_osc_phase           <= 1'b0;
            o_afe_phase           <= 1'b0;
            o_run                 <= 1'b0;
            o_sample_window_count <= RST_WINDOW;
        end
        else
        begin
            o_rec_write           <= gate_write;
            o_rec_dropped         <= gate_drop;
            o_rec_bytes           <= gate_bytes;
            o_rec_data            <= rec_data_next;
            o_led_current_code    <= led_code_next;
            o_led_current_ma      <= led_ma_next;
            o_led_slew_ctrl       <= led_slew_ctrl;
            o_standby             <= st_standby;
            o_bias_on             <= st_idle || st_active;
            o_blocks_on           <= st_active;
            o_ref_phase           <= (seq_next == SEQ_REF);
            o_osc_phase           <= (seq_next == SEQ_OSC);
            o_afe_phase           <= (seq_next == SEQ_AFE);
            o_run                 <= (seq_next == SEQ_RUN);
            o_sample_window_count <= window_reg;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence seq_osc_end;
        (seq_reg == SEQ_OSC) && phase_done && st_active;
    endsequence

    sequence seq_afe_end;
        (seq_reg == SEQ_AFE) && phase_done && st_active;
    endsequence

    chk_current_map: assert property (
        o_led_current_ma == 8'(LED_BASE_MA + 8'(LED_STEP_MA * {4'h0, o_led_current_code})))
        else $error("LED current does not match its code");

    chk_prox_select: assert property (
        (st_prox && prox_current_select) |=> (o_led_current_code == $past(prox_led_current_code)))
        else $error("Proximity current code not selected");

    chk_gest_select: assert property (
        (!st_prox || !prox_current_select) |=> (o_led_current_code == $past(gest_led_current_code)))
        else $error("Gesture current code not selected");

    chk_osc_interval: assert property (
        seq_osc_end |=> (seq_reg == SEQ_AFE) ##0 (cnt_reg == 8'h00))
        else $error("Oscillator phase did not end on its count");

    chk_afe_interval: assert property (
        seq_afe_end |=> (seq_reg == SEQ_RUN) ##0 o_run)
        else $error("Front-end phase did not end on its count");

    chk_standby_decode: assert property (
        st_standby |=> (o_standby && !o_blocks_on && !o_bias_on))
        else $error("Standby did not power down all blocks");

    chk_idle_bias: assert property (
        st_idle |=> (o_bias_on && !o_blocks_on && !o_standby))
        else $error("Idle power decode wrong");

    chk_record_len: assert property (
        (i_rec_valid && st_prox && fifo_format == FMT_XYI && !overrun_guard_en)
        |=> (o_rec_write && o_rec_bytes == REC_BYTES_XYI && o_rec_data[15:0] == $past(i_rec_i)))
        else $error("Six-byte record not written");

    chk_intensity_len: assert property (
        (i_rec_valid && st_prox && fifo_format == FMT_INTENSITY && !overrun_guard_en)
        |=> (o_rec_write && o_rec_bytes == REC_BYTES_I))
        else $error("Two-byte record not written");

    chk_no_store: assert property (
        (st_prox && fifo_format != FMT_INTENSITY && fifo_format != FMT_XYI) |=> !o_rec_write)
        else $error("Record stored for an unsupported format");

    chk_sample_len: assert property (
        (i_rec_valid && (operating_state == OPST_SAMPLE || operating_state == OPST_GESTURE) && !overrun_guard_en)
        |=> (o_rec_write && o_rec_bytes == REC_BYTES_SAMPLE))
        else $error("Sample record not four bytes");

    chk_guard_drop: assert property (
        (i_rec_valid && st_active && overrun_guard_en && ({4'h0, gate_bytes} > i_fifo_free)
         && gate_bytes != REC_BYTES_NONE) |=> (!o_rec_write && o_rec_dropped))
        else $error("Guarded record written without room");

    chk_guard_reset: assert property (
        $rose(i_rst_n) |-> !overrun_guard_en)
        else $error("Overrun guard not clear after reset");

endmodule // ldc_reg_bank

// ==== core/ldc_pkg.sv ====
/*
  Shared constants for the LED drive and operating control register bank.
  Assumes a 16-bit internal register port behind the serial host link.
*/
package ldc_pkg;

    // ============================================================
    // Register map
    localparam logic [7:0]  ADDR_LED_DRIVE    = 8'h41;
    localparam logic [7:0]  ADDR_STARTUP      = 8'h42;
    localparam logic [7:0]  ADDR_FRONTEND     = 8'h43;
    localparam logic [7:0]  ADDR_WINDOW       = 8'h44;
    localparam logic [7:0]  ADDR_OPCTL        = 8'h45;

    // ============================================================
    // Reset values and writable masks (reserved bits are not stored)
    localparam logic [15:0] RST_LED_DRIVE     = 16'h1000;
    localparam logic [15:0] RST_STARTUP       = 16'h4000;
    localparam logic [15:0] RST_FRONTEND      = 16'h0000;
    localparam logic [15:0] RST_WINDOW        = 16'h0000;
    localparam logic [15:0] RST_OPCTL         = 16'h0000;
    localparam logic [15:0] MASK_LED_DRIVE    = 16'h1f7f;
    localparam logic [15:0] MASK_STARTUP      = 16'hffff;
    localparam logic [15:0] MASK_FRONTEND     = 16'h000f;
    localparam logic [15:0] MASK_WINDOW       = 16'hffff;
    localparam logic [15:0] MASK_OPCTL        = 16'h01ff;

    // ============================================================
    // Field positions
    localparam int          POS_GEST_CODE     = 0;
    localparam int          POS_SLEW          = 4;
    localparam int          POS_PROX_CODE     = 8;
    localparam int          POS_PROX_SEL      = 12;
    localparam int          POS_REF_TIME      = 0;
    localparam int          POS_OSC_TIME      = 8;
    localparam int          POS_DIG_TIME      = 12;
    localparam int          POS_FRONTEND_PHASE_COUNT      = 0;
    localparam int          POS_STATE         = 0;
    localparam int          POS_FORMAT        = 4;
    localparam int          POS_GUARD         = 8;

    // ============================================================
    // LED current mapping in mA: base plus step per code
    localparam logic [7:0]  LED_BASE_MA       = 8'h19;
    localparam logic [7:0]  LED_STEP_MA       = 8'h0f;

    // ============================================================
    // Operating state codes and proximity FIFO formats
    localparam logic [3:0]  OPST_STANDBY      = 4'h0;
    localparam logic [3:0]  OPST_PROX         = 4'h1;
    localparam logic [3:0]  OPST_GESTURE      = 4'h2;
    localparam logic [3:0]  OPST_SAMPLE       = 4'h3;
    localparam logic [3:0]  OPST_IDLE         = 4'hf;
    localparam logic [3:0]  FMT_INTENSITY     = 4'h1;
    localparam logic [3:0]  FMT_XYI           = 4'h3;

    // ============================================================
    // Record lengths in bytes
    localparam logic [3:0]  REC_BYTES_NONE    = 4'h0;
    localparam logic [3:0]  REC_BYTES_I       = 4'h2;
    localparam logic [3:0]  REC_BYTES_SAMPLE  = 4'h4;
    localparam logic [3:0]  REC_BYTES_XYI     = 4'h6;

    // ============================================================
    // Start-up sequencer states
    typedef enum logic [4:0]
    {
        SEQ_OFF = 5'b00001,
        SEQ_REF = 5'b00010,
        SEQ_OSC = 5'b00100,
        SEQ_AFE = 5'b01000,
        SEQ_RUN = 5'b10000
    } ldc_seq_type;

endpackage

// ==== core/ldc_record_gate.sv ====
/*
  Record length decode and overrun guard for FIFO writes.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/10ps
module ldc_record_gate
    import ldc_pkg::*;
(
    // Mode and format
    input  wire logic [3:0]  i_state,
    input  wire logic [3:0]  i_format,
    input  wire logic        i_guard_en,
    // Record and FIFO space
    input  wire logic        i_rec_valid,
    input  wire logic [7:0]  i_fifo_free,
    // Decision
    output logic      [3:0]  o_bytes,
    output logic             o_write,
    output logic             o_drop
);

    // ============================================================
    // Length decode
    wire logic is_prox   = (i_state == OPST_PROX);
    wire logic is_sample = (i_state == OPST_SAMPLE) || (i_state == OPST_GESTURE);
    wire logic fits      = ({4'h0, o_bytes} <= i_fifo_free);
    wire logic storing   = i_rec_valid && (o_bytes != REC_BYTES_NONE);

    assign o_bytes = is_sample                            ? REC_BYTES_SAMPLE :
                     (is_prox && i_format == FMT_INTENSITY) ? REC_BYTES_I :
                     (is_prox && i_format == FMT_XYI)       ? REC_BYTES_XYI :
                     REC_BYTES_NONE;

    // A whole record is dropped rather than split, so the reader never sees a torn record.
    assign o_write = storing && (!i_guard_en || fits);
    assign o_drop  = storing && i_guard_en && !fits;

endmodule // ldc_record_gate

// ==== test/ldc_host_model.sv ====
/*
  Host model for the register port: whole 16-bit register writes and reads.
  Assumes one call at a time, with lines changed just after rising edges.
*/
`timescale 1ns/10ps
module ldc_host_model
    import ldc_pkg::*;
(
    // Clock
    input  wire logic        i_clock,
    // Register port
    output logic             o_reg_wr = 1'b0,
    output logic             o_reg_rd = 1'b0,
    output logic      [7:0]  o_reg_addr = 8'h00,
    output logic      [15:0] o_reg_wdata = 16'h0000,
    input  wire logic [15:0] i_reg_rdata
);
    // ============================================================
    // Accesses
    function automatic logic [15:0] field_mask(input logic [7:0] addr);
        case (addr)
            ADDR_LED_DRIVE: return MASK_LED_DRIVE;
            ADDR_FRONTEND:  return MASK_FRONTEND;
            ADDR_OPCTL:     return MASK_OPCTL;
            default:        return 16'hffff;
        endcase
    endfunction

    // Released lines are inverted so a stale value is never mistaken for a live one.
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge i_clock);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= addr;
        o_reg_wdata <= data & field_mask(addr);
        @(posedge i_clock);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~addr;
        o_reg_wdata <= ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(posedge i_clock);
        o_reg_rd   <= 1'b1;
        o_reg_addr <= addr;
        @(posedge i_clock);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~addr;
        #1;
        data = i_reg_rdata;
    endtask

    // The device only stores the window; working out the count is up to the host.
    task automatic program_window(input int pulses, input int period);
        int count;
        count = (100 + pulses * period) * 10 / 313 + 1;
        write_reg(ADDR_WINDOW, count[15:0]);
    endtask
endmodule // ldc_host_model

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the LED drive and operating control bank.
  Assumes the host model owns the register port; the bench drives records and ticks.
*/
`timescale 1ns/10ps
module tb_top
    import ldc_pkg::*;
;
    // ============================================================
    // Signals
    logic        i_clock, i_rst_n = 1'b0, i_reg_wr, i_reg_rd, i_tick_32k = 1'b0, i_rec_valid = 1'b0;
    logic [7:0]  i_reg_addr, i_fifo_free = 8'h00, o_led_current_ma;
    logic [15:0] i_reg_wdata, o_reg_rdata, o_sample_window_count, rd;
    logic [15:0] i_rec_x = 16'h1234, i_rec_y = 16'h5678, i_rec_i = 16'h9abc;
    logic [3:0]  o_rec_bytes, o_led_current_code;
    logic [2:0]  o_led_slew_ctrl;
    logic [47:0] o_rec_data;
    logic        o_rec_write, o_rec_dropped, o_standby, o_bias_on, o_blocks_on;
    logic        o_ref_phase, o_osc_phase, o_afe_phase, o_run;
    logic [3:0]  ph;
    int          mismatches, samples_checked, cycles, n, c;
    logic [15:0] t_rst [6] = '{16'h0000, 16'h1000, 16'h4000, 16'h0000, 16'h0000, 16'h0000};
    logic [3:0]  t_ms  [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
    logic [3:0]  t_st  [9] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h2, 4'h1, 4'h1, 4'h0, 4'hf};
    logic [3:0]  t_fm  [9] = '{4'h1, 4'h3, 4'h2, 4'h5, 4'h0, 4'h3, 4'h3, 4'h1, 4'h3};
    logic        t_gd  [9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0]  t_fr  [9] = '{8'h00, 8'h00, 8'h40, 8'h04, 8'h00, 8'h05, 8'h06, 8'h40, 8'h40};
    logic [3:0]  t_by  [9] = '{4'h2, 4'h6, 4'h0, 4'h4, 4'h4, 4'h6, 4'h6, 4'h0, 4'h0};
    logic        t_wr  [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    assign ph = {o_run, o_afe_phase, o_osc_phase, o_ref_phase};

    ldc_reg_bank i_dut
    (
        .i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .i_tick_32k, .i_rec_valid, .i_rec_x, .i_rec_y, .i_rec_i, .i_fifo_free,
        .o_rec_write, .o_rec_dropped, .o_rec_bytes, .o_rec_data,
        .o_led_current_code, .o_led_current_ma, .o_led_slew_ctrl, .o_standby, .o_bias_on,
        .o_blocks_on, .o_ref_phase, .o_osc_phase, .o_afe_phase, .o_run, .o_sample_window_count
    );
    ldc_host_model i_host
    (
        .i_clock, .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
        .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    // A full run takes well under a thousand cycles; the ceiling leaves ample room.
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    // ============================================================
    // Compare and helper tasks
    task automatic fail(input string what);
        mismatches++;
        $display("wrong value at %0t: %s", $time, what);
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("word %h, expected %h", got, exp));
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("flag %b, expected %b", got, exp));
    endtask
    task automatic cmp_data(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("record %h, expected %h", got, exp));
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic set_mode(input logic guard, input logic [3:0] fmt, input logic [3:0] st);
        i_host.write_reg(ADDR_OPCTL, {7'h00, guard, fmt, st});
        @(posedge i_clock);
        #1;
    endtask
    task automatic offer(input logic [7:0] free);
        @(posedge i_clock);
        i_fifo_free <= free;
        i_rec_valid <= 1'b1;
        @(posedge i_clock);
        i_rec_valid <= 1'b0;
        #1;
    endtask
    // Waits for phase k, holds there without ticks, then gives the single tick it needs.
    task automatic step(input int k);
        for (n = 0; n < 10 && ph[k] !== 1'b1; n++)
            @(posedge i_clock);
        repeat (6) @(posedge i_clock);
        #1;
        cmp_flag(ph[k], 1'b1);
        @(posedge i_clock);
        i_tick_32k <= 1'b1;
        @(posedge i_clock);
        i_tick_32k <= 1'b0;
    endtask

    // ============================================================
    // Tests
    initial
    begin
        repeat (5) @(posedge i_clock);
        cmp_flag(o_standby, 1'b1);
        cmp_word({8'h00, o_led_current_ma}, 16'h0019);
        i_rst_n <= 1'b1;
        for (n = 0; n < 6; n++)
        begin
            i_host.read_reg(8'h40 + 8'(n), rd);
            cmp_word(rd, t_rst[n]);
        end
        i_host.program_window(8, 19);
        i_host.read_reg(ADDR_WINDOW, rd);
        cmp_word(rd, 16'h0009);
        cmp_word(o_sample_window_count, 16'h0009);
        $display("test registers done");
        for (c = 0; c < 16; c++)
        begin
            i_host.write_reg(ADDR_LED_DRIVE, {4'h1, 4'(15 - c), 1'b0, 3'(c), 4'(c)});
            @(posedge i_clock);
            #1;
            cmp_word({8'h00, o_led_current_ma}, 16'(25 + 15 * c));
            cmp_word({13'h0000, o_led_slew_ctrl}, 16'(c & 7));
        end
        i_host.write_reg(ADDR_LED_DRIVE, 16'h1a03);
        set_mode(1'b0, 4'h0, 4'h1);
        cmp_word({8'h00, o_led_current_ma}, 16'h00af);
        i_host.write_reg(ADDR_LED_DRIVE, 16'h0a03);
        @(posedge i_clock);
        #1;
        cmp_word({8'h00, o_led_current_ma}, 16'h0046);
        i_host.write_reg(ADDR_LED_DRIVE, 16'h1a03);
        set_mode(1'b0, 4'h0, 4'h3);
        cmp_word({12'h000, o_led_current_code}, 16'h0003);
        $display("test led drive done");
        for (n = 0; n < 5; n++)
        begin
            set_mode(1'b0, 4'h0, t_ms[n]);
            cmp_flag(o_standby, t_ms[n] == 4'h0);
            cmp_flag(o_bias_on, t_ms[n] != 4'h0);
            cmp_flag(o_blocks_on, t_ms[n] inside {4'h1, 4'h2, 4'h3});
        end
        $display("test modes done");
        set_mode(1'b0, 4'h0, 4'h0);
        i_host.write_reg(ADDR_STARTUP, 16'h4100);
        i_host.write_reg(ADDR_FRONTEND, 16'h0001);
        set_mode(1'b0, 4'h0, 4'h1);
        cmp_flag(o_ref_phase, 1'b1);
        step(1);
        step(2);
        for (n = 0; n < 10 && o_run !== 1'b1; n++)
            @(posedge i_clock);
        #1;
        cmp_flag(o_run, 1'b1);
        $display("test start-up done");
        for (c = 0; c < 9; c++)
        begin
            set_mode(t_gd[c], t_fm[c], t_st[c]);
            offer(t_fr[c]);
            cmp_flag(o_rec_write, t_wr[c]);
            cmp_flag(o_rec_dropped, t_gd[c] && !t_wr[c] && t_by[c] != 4'h0);
            if (t_st[c] != 4'h0 && t_st[c] != 4'hf)
                cmp_word({12'h000, o_rec_bytes}, {12'h000, t_by[c]});
            if (t_wr[c])
                cmp_data(o_rec_data, t_by[c] == 4'h6 ? {i_rec_x, i_rec_y, i_rec_i} :
                    t_by[c] == 4'h4 ? {16'h0000, i_rec_x, i_rec_y} : {32'h0, i_rec_i});
        end
        $display("test records done");
        results();
    end
endmodule // tb_top
